// [include/gst_pkg.sv]
// Shared constants and types of the gated 16-bit timer control block
package gst_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GATE_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_CLK_SEL    = 8'h08;
  localparam logic [7:0] ADDR_GATE_SEL   = 8'h0C;
  localparam logic [7:0] ADDR_COUNT_LO   = 8'h10;
  localparam logic [7:0] ADDR_COUNT_HI   = 8'h14;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h1C;
  localparam logic [7:0] ADDR_INT_CLEAR  = 8'h20;

  // Field positions
  localparam int TC_ON_BIT    = 0;
  localparam int TC_WIDE_BIT  = 1;
  localparam int TC_SYNC_BIT  = 2;
  localparam int TC_PS_LSB    = 4;
  localparam int GC_GATE_LEVEL_STATUS_BIT  = 2;
  localparam int GC_ARM_BIT   = 3;
  localparam int GC_SPM_BIT   = 4;
  localparam int GC_GTM_BIT   = 5;
  localparam int GC_GATE_POLARITY_BIT  = 6;
  localparam int GC_GE_BIT    = 7;
  localparam int INT_OVF_BIT  = 0;
  localparam int INT_GATE_BIT = 1;

  // Reset values
  localparam logic [7:0]  TIMER_CTRL_RST = 8'h00;
  localparam logic [7:0]  GATE_CTRL_RST  = 8'h00;
  localparam logic [3:0]  CLK_SEL_RST    = 4'h0;
  localparam logic [4:0]  GATE_SEL_RST   = 5'h00;
  localparam logic [15:0] COUNT_RST      = 16'h0000;
  localparam logic [1:0]  INT_RST        = 2'h0;

  // Source codes and counts
  localparam logic [3:0]  CS_PIN       = 4'h0;
  localparam logic [3:0]  CS_SYS4      = 4'h1;
  localparam logic [3:0]  CS_SYS       = 4'h2;
  localparam logic [3:0]  CS_RSVD_MIN  = 4'hE;
  localparam logic [4:0]  GSS_LAST     = 5'h10;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  localparam int          CLK_SRC_N    = 16;
  localparam int          GATE_SRC_N   = 17;

  typedef enum logic [1:0] {SRC_EXT, SRC_SYS, SRC_SYS4} gst_src_mode_t;
  typedef enum logic [1:0] {SP_IDLE, SP_WAIT, SP_RUN} gst_sp_state_t;

  // Raw clock and gate candidates, indexed by select code
  typedef struct packed {
    logic [CLK_SRC_N-1:0]  clk;
    logic [GATE_SRC_N-1:0] gate;
  } gst_src_t;

  typedef struct packed {
    logic [1:0] prescale;
    logic       sync_bypass;
    logic       wide_access_mode;
    logic       on;
  } gst_tctl_t;

  typedef struct packed {
    logic gate_enable;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic single_pulse_mode;
  } gst_gctl_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } gst_aphase_t;

endpackage

// [logic/gst_tick_gen.sv]
// Timer clock conditioning: synchroniser, edge detect, divide-by-four and prescaler
`timescale 1ns/100ps
module gst_tick_gen (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   clk_raw,
  input  wire gst_pkg::gst_src_mode_t src_mode,
  input  wire logic                   sync_bypass,
  input  wire logic [1:0]             prescale,
  input  wire logic                   clr,
  output logic                        base_tick,
  output logic                        tick
);
  import gst_pkg::*;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [1:0] div;
    logic [2:0] pre;
  } gst_tick_state_t;

  gst_tick_state_t s_r;
  gst_tick_state_t s_nxt;
  logic            sel;
  logic [2:0]      pre_last;

  always_comb begin
    s_nxt = s_r;
    sel = sync_bypass ? clk_raw : s_r.sync2;
    pre_last = 3'((4'h1 << prescale) - 4'h1);
    case (src_mode)
      SRC_SYS:  base_tick = clk_en;
      SRC_SYS4: base_tick = clk_en & (s_r.div == DIV4_LAST);
      default:  base_tick = clk_en & sel & ~s_r.prev;
    endcase
    tick = base_tick & ~clr & (s_r.pre == pre_last);
    s_nxt.sync1 = clk_raw;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = sel;
    s_nxt.div = s_r.div + 2'h1;
    if (clr) begin
      s_nxt.pre = 3'h0;
    end else if (base_tick) begin
      s_nxt.pre = tick ? 3'h0 : s_r.pre + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  prescale_two_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && src_mode == SRC_SYS && prescale == 2'h1) |=> !tick)
    else $error("tick repeated within a divide-by-two period");

  sys4_spacing_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (base_tick && src_mode == SRC_SYS4) |=> (src_mode != SRC_SYS4 || !base_tick))
    else $error("quarter-rate base tick on consecutive cycles");

  ext_sync_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (base_tick && src_mode == SRC_EXT && !sync_bypass && $past(clk_en, 1) && $past(clk_en, 2)
     && $past(clk_en, 3) && $past(sync_bypass, 1)== 1'b0) |-> ($past(clk_raw, 2) && !$past(clk_raw, 3)))
    else $error("synchronised edge not two cycles after raw edge");

endmodule

// [logic/gst_timer.sv]
// Gated 16-bit timer with clock select, prescaler, gate logic and AHB-Lite registers
//
// Summary of operation
// - two-bit field divides timer clock by 1/2/4/8
// - system clock sources skip the synchroniser
// - other sources synchronised unless sync bypass set
// - mode bit selects coherent 16-bit count access
// - on bit enables counting; off clears toggle
// - gate enable makes counting follow gate
// - polarity bit selects active-high or active-low gate
// - toggle mode divides gate by rising edges
// - armed status reads one until pulse completes
// - clearing single-pulse mode clears armed status
// - gate level status readable regardless of enable
// - four-bit field selects timer clock, two reserved
// - five-bit field selects gate, high codes reserved
// - unimplemented control bits read as zero
// - control bits reset to zero on reset
// - count wraps to zero and sets overflow flag
// - gate level falling edge sets gate event flag
// - single pulse runs first edge to trailing edge
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
module gst_timer (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              clk_en,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire gst_pkg::gst_src_t src,
  output logic [15:0]            count_value,
  output logic                   irq
);
  import gst_pkg::*;

  typedef struct packed {
    gst_tctl_t     tctl;
    gst_gctl_t     gctl;
    logic [3:0]    clk_sel;
    logic [4:0]    gate_sel;
    logic [15:0]   count;
    logic [7:0]    hi_buf;
    gst_sp_state_t sp;
    logic          tff;
    logic          gate_prev_raw;
    logic          gate_act_prev;
    logic          gate_level_status;
    logic [1:0]    int_st;
    logic [1:0]    int_en;
    gst_aphase_t   ap;
    logic          rd_wait;
    logic [31:0]   hrdata;
  } gst_timer_state_t;

  gst_timer_state_t s_r;
  gst_timer_state_t s_nxt;
  logic             clk_raw;
  gst_src_mode_t    src_mode;
  logic             base_tick;
  logic             tick;
  logic             gate_raw;
  logic             gate_rise_raw;
  logic             gate_tog;
  logic             gate_act;
  logic             gate_val;
  logic             count_en;
  logic             wr_now;
  logic             rd_now;
  logic [7:0]       wbyte;
  logic [1:0]       int_set;
  logic [1:0]       int_clr;
  logic [16:0]      inc;

  // Register read view; unimplemented bits are zero
  function automatic logic [7:0] reg_view(input gst_timer_state_t st, input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      ADDR_TIMER_CTRL: begin
        v[TC_PS_LSB+:2] = st.tctl.prescale;
        v[TC_SYNC_BIT] = st.tctl.sync_bypass;
        v[TC_WIDE_BIT] = st.tctl.wide_access_mode;
        v[TC_ON_BIT] = st.tctl.on;
      end
      ADDR_GATE_CTRL: begin
        v[GC_GE_BIT] = st.gctl.gate_enable;
        v[GC_GATE_POLARITY_BIT] = st.gctl.gate_polarity;
        v[GC_GTM_BIT] = st.gctl.gate_toggle_mode;
        v[GC_SPM_BIT] = st.gctl.single_pulse_mode;
        v[GC_ARM_BIT] = (st.sp != SP_IDLE);
        v[GC_GATE_LEVEL_STATUS_BIT] = st.gate_level_status;
      end
      ADDR_CLK_SEL:    v = {4'h0, st.clk_sel};
      ADDR_GATE_SEL:   v = {3'h0, st.gate_sel};
      ADDR_COUNT_LO:   v = st.count[7:0];
      ADDR_COUNT_HI:   v = st.tctl.wide_access_mode ? st.hi_buf : st.count[15:8];
      ADDR_INT_STATUS: v = {6'h00, st.int_st};
      ADDR_INT_ENABLE: v = {6'h00, st.int_en};
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  gst_tick_gen u_tick (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .clk_en      (clk_en),
    .clk_raw     (clk_raw),
    .src_mode    (src_mode),
    .sync_bypass (s_r.tctl.sync_bypass),
    .prescale    (s_r.tctl.prescale),
    .clr         (~s_r.tctl.on),
    .base_tick   (base_tick),
    .tick        (tick)
  );

  always_comb begin
    // Clock source selection
    clk_raw = (s_r.clk_sel >= CS_RSVD_MIN) ? 1'b0 : src.clk[s_r.clk_sel];
    case (s_r.clk_sel)
      CS_SYS:  src_mode = SRC_SYS;
      CS_SYS4: src_mode = SRC_SYS4;
      default: src_mode = SRC_EXT;
    endcase

    // Gate path
    gate_raw = (s_r.gate_sel > GSS_LAST) ? 1'b0 : src.gate[s_r.gate_sel];
    gate_rise_raw = gate_raw & ~s_r.gate_prev_raw;
    gate_tog = s_r.gctl.gate_toggle_mode ? s_r.tff : gate_raw;
    gate_act = s_r.gctl.gate_polarity ? gate_tog : ~gate_tog;
    if (s_r.gctl.single_pulse_mode) begin
      gate_val = (s_r.sp == SP_RUN) & gate_act;
    end else begin
      gate_val = gate_act;
    end
    count_en = s_r.tctl.on & (~s_r.gctl.gate_enable | gate_val);

    // Bus phases
    hreadyout = ~(s_r.ap.valid & ~s_r.ap.write & ~s_r.rd_wait);
    hresp = 1'b0;
    wr_now = s_r.ap.valid & s_r.ap.write;
    rd_now = s_r.ap.valid & ~s_r.ap.write & ~s_r.rd_wait;
    wbyte = hwdata[7:0];

    s_nxt = s_r;
    int_set = 2'h0;
    int_clr = 2'h0;

    // Toggle flip-flop, held clear when off or toggle disabled
    if (!s_r.tctl.on || !s_r.gctl.gate_toggle_mode) begin
      s_nxt.tff = 1'b0;
    end else if (gate_rise_raw) begin
      s_nxt.tff = ~s_r.tff;
    end
    s_nxt.gate_prev_raw = gate_raw;
    s_nxt.gate_act_prev = gate_act;

    // Single-pulse sequence
    case (s_r.sp)
      SP_WAIT: begin
        if (gate_act && !s_r.gate_act_prev) begin
          s_nxt.sp = SP_RUN;
        end
      end
      SP_RUN: begin
        if (!gate_act) begin
          s_nxt.sp = SP_IDLE;
        end
      end
      default: s_nxt.sp = SP_IDLE;
    endcase

    // Gate level and gate event
    s_nxt.gate_level_status = gate_val;
    if (s_r.gate_level_status && !gate_val) begin
      int_set[INT_GATE_BIT] = 1'b1;
    end

    // Counting
    inc = {1'b0, s_r.count} + 17'h00001;
    if (tick && count_en) begin
      s_nxt.count = inc[15:0];
      if (s_r.count == COUNT_MAX) begin
        int_set[INT_OVF_BIT] = 1'b1;
      end
    end

    // Register writes, taking precedence over counting
    if (wr_now) begin
      case (s_r.ap.addr)
        ADDR_TIMER_CTRL: begin
          s_nxt.tctl.prescale = wbyte[TC_PS_LSB+:2];
          s_nxt.tctl.sync_bypass = wbyte[TC_SYNC_BIT];
          s_nxt.tctl.wide_access_mode = wbyte[TC_WIDE_BIT];
          s_nxt.tctl.on = wbyte[TC_ON_BIT];
        end
        ADDR_GATE_CTRL: begin
          s_nxt.gctl.gate_enable = wbyte[GC_GE_BIT];
          s_nxt.gctl.gate_polarity = wbyte[GC_GATE_POLARITY_BIT];
          s_nxt.gctl.gate_toggle_mode = wbyte[GC_GTM_BIT];
          s_nxt.gctl.single_pulse_mode = wbyte[GC_SPM_BIT];
          if (!wbyte[GC_ARM_BIT]) begin
            s_nxt.sp = SP_IDLE;
          end else if (s_r.sp == SP_IDLE) begin
            s_nxt.sp = SP_WAIT;
          end
        end
        ADDR_CLK_SEL:  s_nxt.clk_sel = wbyte[3:0];
        ADDR_GATE_SEL: s_nxt.gate_sel = wbyte[4:0];
        ADDR_COUNT_LO: begin
          if (s_r.tctl.wide_access_mode) begin
            s_nxt.count = {s_r.hi_buf, wbyte};
          end else begin
            s_nxt.count[7:0] = wbyte;
          end
        end
        ADDR_COUNT_HI: begin
          if (s_r.tctl.wide_access_mode) begin
            s_nxt.hi_buf = wbyte;
          end else begin
            s_nxt.count[15:8] = wbyte;
          end
        end
        ADDR_INT_ENABLE: s_nxt.int_en = wbyte[1:0];
        ADDR_INT_CLEAR:  int_clr = wbyte[1:0];
        default: ;
      endcase
    end
    if (!s_nxt.gctl.single_pulse_mode) begin
      s_nxt.sp = SP_IDLE;
    end

    // Sticky flags, set wins over clear
    s_nxt.int_st = (s_r.int_st & ~int_clr) | int_set;

    // Reads: one wait state, data registered
    if (rd_now) begin
      s_nxt.hrdata = {24'h000000, reg_view(s_r, s_r.ap.addr)};
      s_nxt.rd_wait = 1'b1;
      if (s_r.ap.addr == ADDR_COUNT_LO && s_r.tctl.wide_access_mode) begin
        s_nxt.hi_buf = s_r.count[15:8];
      end
    end
    if (hreadyout) begin
      s_nxt.rd_wait = 1'b0;
      s_nxt.ap.valid = hsel & htrans[1] & hready;
      s_nxt.ap.write = hwrite;
      s_nxt.ap.addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.tctl <= gst_tctl_t'({TIMER_CTRL_RST[TC_PS_LSB+:2], TIMER_CTRL_RST[TC_SYNC_BIT],
                               TIMER_CTRL_RST[TC_WIDE_BIT], TIMER_CTRL_RST[TC_ON_BIT]});
      s_r.gctl <= gst_gctl_t'(GATE_CTRL_RST[7:4]);
      s_r.clk_sel <= CLK_SEL_RST;
      s_r.gate_sel <= GATE_SEL_RST;
      s_r.count <= COUNT_RST;
      s_r.int_st <= INT_RST;
      s_r.int_en <= INT_RST;
      s_r.sp <= SP_IDLE;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata;
  assign count_value = s_r.count;
  assign irq = |(s_r.int_st & s_r.int_en);

  off_clears_toggle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && !s_r.tctl.on) |=> !s_r.tff)
    else $error("toggle flip-flop not cleared while timer off");

  gate_enable_use_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && tick && s_r.tctl.on && !s_r.gctl.gate_enable && !wr_now)
      |=> s_r.count == $past(s_r.count) + 16'h0001)
    else $error("timer did not count with gate enable clear");

  gate_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.tctl.on && s_r.gctl.gate_enable && !s_r.gctl.gate_toggle_mode && !s_r.gctl.single_pulse_mode)
      |-> count_en == (s_r.gctl.gate_polarity ? gate_raw : !gate_raw))
    else $error("gate polarity not honoured");

  toggle_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && s_r.tctl.on && s_r.gctl.gate_toggle_mode && gate_rise_raw) |=> s_r.tff != $past(s_r.tff))
    else $error("toggle flip-flop missed a rising gate edge");

  spm_clears_arm_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !s_r.gctl.single_pulse_mode |-> s_r.sp == SP_IDLE)
    else $error("armed status set without single-pulse mode");

  pulse_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && s_r.sp == SP_RUN && !gate_act) |=> s_r.sp == SP_IDLE)
    else $error("single pulse did not complete on trailing edge");

  gate_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> s_r.gate_level_status == $past(gate_val))
    else $error("gate level status lags gate value");

  overflow_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && tick && count_en && s_r.count == COUNT_MAX && !wr_now)
      |=> (s_r.count == 16'h0000 && s_r.int_st[INT_OVF_BIT]))
    else $error("rollover did not wrap or flag overflow");

  gate_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && s_r.gate_level_status && !gate_val) |=> s_r.int_st[INT_GATE_BIT])
    else $error("falling gate level did not set gate event flag");

  clk_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s_r.clk_sel >= CS_RSVD_MIN) |-> !clk_raw)
    else $error("reserved clock select drives a clock");

endmodule

// [testbench/gst_src_model.sv]
// Far-side clock and gate sources feeding the timer's select muxes
`timescale 1ns/100ps
module gst_src_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       gate_lvl,
  input  wire logic [4:0] gate_code,
  output gst_pkg::gst_src_t src
);
  import gst_pkg::*;

  logic [2:0] div_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // Oscillator-like sources run free at one eighth of hclk
  always_comb begin
    for (int i = 0; i < CLK_SRC_N; i++) begin
      src.clk[i] = div_r[2];
    end
    // Unselected gate lines show the opposite level so a wrong pick is seen
    for (int j = 0; j < GATE_SRC_N; j++) begin
      src.gate[j] = (gate_code == 5'(j)) ? gate_lvl : ~gate_lvl;
    end
  end
endmodule

// [testbench/tb_gst_timer.sv]
// Self-checking bench for the gated 16-bit timer over AHB-Lite
`timescale 1ns/100ps
module tb_gst_timer;
  import gst_pkg::*;

  logic        hclk      = 1'b0;
  logic        hresetn   = 1'b0;
  logic        clk_en    = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        gate_lvl  = 1'b0;
  logic [4:0]  gate_code = 5'h00;
  logic        rd_pend   = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [31:0] hrdata;
  logic [15:0] count_value;
  gst_src_t    src;
  logic [31:0] exp_q[$];
  logic [7:0]  rnd;
  int          err_total = 0;
  int          num_checks = 0;

  always #2 hclk = ~hclk;

  gst_timer gst_timer_i (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .src(src), .count_value(count_value), .irq(irq)
  );

  gst_src_model gst_src_model_i (
    .hclk(hclk), .hresetn(hresetn), .gate_lvl(gate_lvl), .gate_code(gate_code), .src(src)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Single transfer; address phase held until hready, then data phase until hready
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic moves(input logic e);
    logic [15:0] c0;
    cyc(3);
    c0 = count_value;
    cyc(12);
    check({31'h0, count_value !== c0}, {31'h0, e});
  endtask

  task automatic period(input int e);
    logic [15:0] c0;
    int          k;
    for (int n = 0; n < 2; n++) begin
      c0 = count_value;
      k = 0;
      while (count_value === c0 && k < 200) begin
        @(posedge hclk);
        k++;
      end
    end
    check(k, e);
  endtask

  // Read monitor takes the oldest expectation when a read data phase ends
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      rd_pend <= 1'b0;
    end
    if (htrans[1] && !hwrite && hreadyout === 1'b1 && clk_en) begin
      rd_pend <= 1'b1;
    end
  end

  // About 25000 cycles, several times the expected run
  initial begin
    #100000;
    err_total++;
    stop_test();
  end

  initial begin
    void'($urandom(38491));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    clk_en  <= 1'b1;
    @(posedge hclk);
    rd(ADDR_TIMER_CTRL, 32'h0);
    rd(ADDR_GATE_CTRL, 32'h04);
    rd(ADDR_CLK_SEL, 32'h0);
    rd(ADDR_GATE_SEL, 32'h0);
    rd(ADDR_INT_STATUS, 32'h0);
    rd(8'h40, 32'h0);
    wr(ADDR_TIMER_CTRL, $urandom | 32'hFF);
    rd(ADDR_TIMER_CTRL, 32'h37);
    wr(ADDR_CLK_SEL, $urandom | 32'hFF);
    rd(ADDR_CLK_SEL, 32'h0F);
    wr(ADDR_GATE_SEL, $urandom | 32'hFF);
    rd(ADDR_GATE_SEL, 32'h1F);
    wr(ADDR_GATE_SEL, 32'h0);
    wr(ADDR_CLK_SEL, {28'h0, CS_SYS});
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_TIMER_CTRL, 32'(p << TC_PS_LSB) | 32'h1);
      period(1 << p);
    end
    wr(ADDR_CLK_SEL, {28'h0, CS_SYS4});
    wr(ADDR_TIMER_CTRL, 32'h05);
    period(4);
    wr(ADDR_TIMER_CTRL, 32'h01);
    period(4);
    for (int c = 0; c < 16; c++) begin
      if (c == 1 || c == 2) continue;
      wr(ADDR_CLK_SEL, 32'(c));
      for (int s = 0; s < 2; s++) begin
        wr(ADDR_TIMER_CTRL, s ? 32'h05 : 32'h01);
        if (c < 14) period(8);
        else moves(1'b0);
      end
    end
    wr(ADDR_CLK_SEL, {28'h0, CS_SYS});
    wr(ADDR_TIMER_CTRL, 32'h01);
    for (int g = 0; g < 18; g++) begin
      gate_code <= 5'(g);
      gate_lvl  <= 1'b1;
      wr(ADDR_GATE_SEL, 32'(g));
      wr(ADDR_GATE_CTRL, 32'hC0);
      moves(g < 17);
      gate_lvl <= 1'b0;
      moves(1'b0);
    end
    gate_code <= 5'h00;
    wr(ADDR_GATE_SEL, 32'h0);
    wr(ADDR_GATE_CTRL, 32'h80);
    moves(1'b1);
    gate_lvl <= 1'b1;
    moves(1'b0);
    wr(ADDR_GATE_CTRL, 32'h40);
    moves(1'b1);
    rd(ADDR_GATE_CTRL, 32'h44);
    gate_lvl <= 1'b0;
    cyc(3);
    rd(ADDR_GATE_CTRL, 32'h40);
    wr(ADDR_TIMER_CTRL, 32'h00);
    moves(1'b0);
    wr(ADDR_COUNT_HI, 32'h0);
    wr(ADDR_COUNT_LO, 32'h0);
    wr(ADDR_TIMER_CTRL, 32'h01);
    wr(ADDR_INT_CLEAR, 32'h3);
    wr(ADDR_INT_ENABLE, 32'h2);
    gate_lvl <= 1'b1;
    cyc(4);
    gate_lvl <= 1'b0;
    cyc(4);
    rd(ADDR_INT_STATUS, 32'h2);
    check(irq, 1'b1);
    wr(ADDR_INT_ENABLE, 32'h0);
    cyc(1);
    check(irq, 1'b0);
    wr(ADDR_INT_CLEAR, 32'h2);
    rd(ADDR_INT_STATUS, 32'h0);
    wr(ADDR_TIMER_CTRL, 32'h00);
    wr(ADDR_COUNT_HI, 32'hFF);
    wr(ADDR_COUNT_LO, 32'hFE);
    wr(ADDR_INT_CLEAR, 32'h3);
    wr(ADDR_INT_ENABLE, 32'h1);
    cyc(1);
    check(irq, 1'b0);
    wr(ADDR_TIMER_CTRL, 32'h01);
    cyc(6);
    rd(ADDR_INT_STATUS, 32'h1);
    check(irq, 1'b1);
    check({31'h0, count_value < 16'h0010}, 32'h1);
    wr(ADDR_INT_CLEAR, 32'h1);
    wr(ADDR_GATE_CTRL, 32'hE0);
    moves(1'b0);
    for (int t = 0; t < 2; t++) begin
      gate_lvl <= 1'b1;
      cyc(3);
      gate_lvl <= 1'b0;
      moves(t == 0);
    end
    gate_lvl <= 1'b1;
    cyc(3);
    gate_lvl <= 1'b0;
    wr(ADDR_TIMER_CTRL, 32'h00);
    wr(ADDR_TIMER_CTRL, 32'h01);
    moves(1'b0);
    wr(ADDR_GATE_CTRL, 32'hD0);
    wr(ADDR_GATE_CTRL, 32'hD8);
    rd(ADDR_GATE_CTRL, 32'hD8);
    moves(1'b0);
    gate_lvl <= 1'b1;
    moves(1'b1);
    gate_lvl <= 1'b0;
    cyc(3);
    rd(ADDR_GATE_CTRL, 32'hD0);
    gate_lvl <= 1'b1;
    moves(1'b0);
    gate_lvl <= 1'b0;
    wr(ADDR_GATE_CTRL, 32'hD8);
    wr(ADDR_GATE_CTRL, 32'hC8);
    rd(ADDR_GATE_CTRL, 32'hC0);
    rnd = 8'($urandom);
    wr(ADDR_GATE_CTRL, 32'h0);
    wr(ADDR_TIMER_CTRL, 32'h02);
    wr(ADDR_COUNT_HI, 32'hAB);
    wr(ADDR_COUNT_LO, {24'h0, rnd});
    cyc(1);
    check(count_value, {16'h0, 8'hAB, rnd});
    wr(ADDR_COUNT_HI, 32'h55);
    cyc(1);
    check(count_value, {16'h0, 8'hAB, rnd});
    rd(ADDR_COUNT_LO, {24'h0, rnd});
    rd(ADDR_COUNT_HI, 32'hAB);
    wr(ADDR_COUNT_HI, 32'h55);
    wr(ADDR_COUNT_LO, 32'h11);
    cyc(1);
    check(count_value, 32'h5511);
    wr(ADDR_TIMER_CTRL, 32'h00);
    wr(ADDR_COUNT_HI, 32'h77);
    cyc(1);
    check(count_value, 32'h7711);
    cyc(2);
    stop_test();
  end
endmodule
